// ### pkg/ppsid_pkg.sv
package ppsid_pkg;
   localparam int NUM_PORTS = 2;
   localparam int CLK_HZ = 10000000;
   // debounce times in their own units
   localparam int CON_DEB_MS = 341;
   localparam int BIAS_DEB_US = 52;
   localparam int CON_DEB_CYC = CON_DEB_MS * (CLK_HZ / 1000);
   localparam int BIAS_DEB_CYC = BIAS_DEB_US * (CLK_HZ / 1000000);

   // wishbone word offsets (byte address = 4 * index)
   localparam logic [3:0] IDX_PAGE_PORT = 4'h0;
   localparam logic [3:0] IDX_IRQ_STAT  = 4'h1;
   localparam logic [3:0] IDX_IRQ_MASK  = 4'h2;
   localparam logic [3:0] IDX_PG_LINE   = 4'h8;
   localparam logic [3:0] IDX_PG_SPEED  = 4'h9;
   localparam logic [3:0] IDX_OUI_HI    = 4'hA;
   localparam logic [3:0] IDX_OUI_MID   = 4'hB;
   localparam logic [3:0] IDX_OUI_LO    = 4'hC;
   localparam logic [3:0] IDX_PART_HI   = 4'hD;
   localparam logic [3:0] IDX_PART_MID  = 4'hE;
   localparam logic [3:0] IDX_PART_LO   = 4'hF;

   localparam logic [2:0] PAGE_PORT  = 3'h0;
   localparam logic [2:0] PAGE_IDENT = 3'h1;
   localparam logic [2:0] PAGE_VEND  = 3'h7;

   localparam logic [7:0] COMPLIANCE_VAL = 8'h01;
   // arbitrary identity values
   localparam logic [23:0] MAKER_OUI_VAL = 24'h123456;
   localparam logic [23:0] PART_CODE_VAL = 24'hABCDEF;

   localparam logic [2:0] SPEED_MAX = 3'h2;
   localparam logic [1:0] LINE_INVALID = 2'h0;

   // port page field positions, first field in the lsb
   localparam int B_DIS = 0;
   localparam int B_BIAS = 1;
   localparam int B_CON = 2;
   localparam int B_CHILD = 3;
   localparam int B_FAULT = 3;
   localparam int B_PIE = 4;

   typedef struct packed {
      logic [1:0] a_line;
      logic [1:0] b_line;
      logic       child;
      logic       cable_present;
      logic       bias_raw;
      logic [2:0] peer_speed;
      logic       resume_fault;
      logic       suspend_fault;
   } ppsid_port_in_t;

   typedef struct packed {
      logic [2:0] page;
      logic [3:0] port;
   } ppsid_sel_t;
endpackage : ppsid_pkg

// ### verilog/ppsid_regs.sv
`timescale 1ns/1ps
// Operation
// - report A-pair line state, 2-bit code
// - report B-pair line state, same code
// - child flag; inactive ports read child
// - connected after 341 ms stable connection
// - bias after 52 us continuous detection
// - port disable bit, hardware reset clears
// - 3-bit neighbor speed field of peer
// - never report speed code above 010
// - enabled port event sets event flag
// - fault set on resume or suspend failure
// - fault cleared by writing one
// - page 1 maps identification at 8-15
// - page 7 selects vendor-dependent page
// - compliance level 01h at address 8
// - 24-bit maker id, MSB at 1010b
// - 24-bit part_code, MSB at 1101b
// - unimplemented port reads all zero
// - port selector chooses port, page 0
module ppsid_regs
   import ppsid_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  ce_i,
   input  wire logic                  bus_reset_i,
   input  wire logic                  tree_id_done_i,
   input  wire logic                  self_id_done_i,
   input  wire ppsid_port_in_t        port_i [NUM_PORTS],
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [5:0]            wb_adr_i,
   input  wire logic [31:0]           wb_dat_i,
   input  wire logic [3:0]            wb_sel_i,
   output logic      [31:0]           wb_dat_o,
   output logic                       wb_ack_o,
   output logic      [NUM_PORTS-1:0]  port_disable_o,
   output logic                       irq_o
);
   ppsid_sel_t               sel_q;
   logic [NUM_PORTS-1:0]     dis_q;
   logic [NUM_PORTS-1:0]     pie_q;
   logic [NUM_PORTS-1:0]     fault_q;
   logic [NUM_PORTS-1:0]     con_q;
   logic [NUM_PORTS-1:0]     bias_q;
   logic [NUM_PORTS-1:0]     child_valid_q;
   logic [NUM_PORTS-1:0]     speed_valid_q;
   logic [NUM_PORTS-1:0]     con_prev_q;
   logic [NUM_PORTS-1:0]     bias_prev_q;
   logic [NUM_PORTS-1:0]     dis_prev_q;
   logic [NUM_PORTS-1:0]     fault_prev_q;
   logic [31:0]              con_cnt_q  [NUM_PORTS];
   logic [15:0]              bias_cnt_q [NUM_PORTS];
   logic                     pei_q;
   logic                     pei_mask_q;
   logic [NUM_PORTS-1:0]     event_s;
   logic                     req_s;
   logic                     wr_s;
   logic [3:0]               idx_s;
   logic                     port_ok_s;
   logic [7:0]               rd_s;
   logic [0:0]               psel_s;

   assign req_s  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_s   = req_s && wb_we_i && wb_sel_i[0] && ce_i;
   assign idx_s  = wb_adr_i[5:2];
   assign port_ok_s = sel_q.port < 4'(NUM_PORTS);
   assign psel_s = sel_q.port[0:0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_q <= '0;
      end else if (wr_s && idx_s == IDX_PAGE_PORT) begin
         sel_q.page <= wb_dat_i[6:4];
         sel_q.port <= wb_dat_i[3:0];
      end
   end

   // disable, enable: cleared by hardware reset or by writing zero, not by bus reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dis_q <= '0;
         pie_q <= '0;
      end else if (wr_s && sel_q.page == PAGE_PORT && port_ok_s) begin
         if (idx_s == IDX_PG_LINE) begin
            dis_q[psel_s] <= wb_dat_i[B_DIS];
         end
         if (idx_s == IDX_PG_SPEED) begin
            pie_q[psel_s] <= wb_dat_i[B_PIE];
         end
      end
   end

   // fault: set beats a simultaneous write-one clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fault_q <= '0;
      end else if (ce_i) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (port_i[p].resume_fault || port_i[p].suspend_fault) begin
               fault_q[p] <= 1'b1;
            end else if (wr_s && sel_q.page == PAGE_PORT && port_ok_s
                         && idx_s == IDX_PG_SPEED
                         && psel_s == 1'(p)
                         && wb_dat_i[B_FAULT]) begin
               fault_q[p] <= 1'b0;
            end
         end
      end
   end

   // debounce: counters restart on any drop, unaffected by bus reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         con_q  <= '0;
         bias_q <= '0;
         for (int p = 0; p < NUM_PORTS; p++) begin
            con_cnt_q[p]  <= '0;
            bias_cnt_q[p] <= '0;
         end
      end else if (ce_i) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (!port_i[p].cable_present) begin
               con_cnt_q[p] <= '0;
               con_q[p]     <= 1'b0;
            end else if (con_cnt_q[p] < 32'(CON_DEB_CYC - 1)) begin
               con_cnt_q[p] <= con_cnt_q[p] + 32'h1;
            end else begin
               con_q[p] <= 1'b1;
            end
            if (!port_i[p].bias_raw) begin
               bias_cnt_q[p] <= '0;
               bias_q[p]     <= 1'b0;
            end else if (bias_cnt_q[p] < 16'(BIAS_DEB_CYC - 1)) begin
               bias_cnt_q[p] <= bias_cnt_q[p] + 16'h1;
            end else begin
               bias_q[p] <= 1'b1;
            end
         end
      end
   end

   // validity of tree and self-id derived fields across bus reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         child_valid_q <= '0;
         speed_valid_q <= '0;
      end else if (ce_i) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (bus_reset_i) begin
               child_valid_q[p] <= 1'b0;
               speed_valid_q[p] <= 1'b0;
            end else begin
               if (tree_id_done_i) begin
                  child_valid_q[p] <= 1'b1;
               end
               if (self_id_done_i) begin
                  speed_valid_q[p] <= 1'b1;
               end
            end
         end
      end
   end

   // port events: change of bias, con, dis or fault
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         event_s[p] = pie_q[p] && ((con_q[p] != con_prev_q[p])
                      || (bias_q[p] != bias_prev_q[p])
                      || (dis_q[p] != dis_prev_q[p])
                      || (fault_q[p] != fault_prev_q[p]));
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         con_prev_q   <= '0;
         bias_prev_q  <= '0;
         dis_prev_q   <= '0;
         fault_prev_q <= '0;
      end else if (ce_i) begin
         con_prev_q   <= con_q;
         bias_prev_q  <= bias_q;
         dis_prev_q   <= dis_q;
         fault_prev_q <= fault_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pei_q <= 1'b0;
      end else if (ce_i) begin
         if (|event_s) begin
            pei_q <= 1'b1;
         end else if (wr_s && idx_s == IDX_IRQ_STAT && wb_dat_i[0]) begin
            pei_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pei_mask_q <= 1'b0;
      end else if (wr_s && idx_s == IDX_IRQ_MASK) begin
         pei_mask_q <= wb_dat_i[0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o          <= 1'b0;
         port_disable_o <= '0;
      end else if (ce_i) begin
         irq_o          <= pei_q && pei_mask_q;
         port_disable_o <= dis_q;
      end
   end

   // read mux; page 7 contents are not implemented and read zero
   always_comb begin
      logic [2:0] spd;
      logic       ch;
      rd_s = '0;
      spd  = port_i[psel_s].peer_speed;
      ch   = port_i[psel_s].child || dis_q[psel_s]
             || fault_q[psel_s] || !con_q[psel_s]
             || !child_valid_q[psel_s];
      if (spd > SPEED_MAX || !speed_valid_q[psel_s]) begin
         spd = SPEED_MAX;
      end
      case (idx_s)
         IDX_PAGE_PORT: rd_s = {1'b0, sel_q.page, sel_q.port};
         IDX_IRQ_STAT:  rd_s = {7'h00, pei_q};
         IDX_IRQ_MASK:  rd_s = {7'h00, pei_mask_q};
         default: begin
            if (idx_s >= IDX_PG_LINE) begin
               if (sel_q.page == PAGE_PORT && port_ok_s) begin
                  if (idx_s == IDX_PG_LINE) begin
                     rd_s = {port_i[psel_s].a_line,
                             port_i[psel_s].b_line,
                             ch, con_q[psel_s],
                             bias_q[psel_s], dis_q[psel_s]};
                  end else if (idx_s == IDX_PG_SPEED) begin
                     rd_s = {spd, pie_q[psel_s],
                             fault_q[psel_s], 3'h0};
                  end
               end else if (sel_q.page == PAGE_IDENT) begin
                  case (idx_s)
                     IDX_PG_LINE:  rd_s = COMPLIANCE_VAL;
                     IDX_OUI_HI:   rd_s = MAKER_OUI_VAL[23:16];
                     IDX_OUI_MID:  rd_s = MAKER_OUI_VAL[15:8];
                     IDX_OUI_LO:   rd_s = MAKER_OUI_VAL[7:0];
                     IDX_PART_HI:  rd_s = PART_CODE_VAL[23:16];
                     IDX_PART_MID: rd_s = PART_CODE_VAL[15:8];
                     IDX_PART_LO:  rd_s = PART_CODE_VAL[7:0];
                     default:      rd_s = '0;
                  endcase
               end
            end
         end
      endcase
   end

   // one-wait-state slave; writes to read-only locations fall through
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else if (ce_i) begin
         wb_ack_o <= req_s;
         if (req_s && !wb_we_i) begin
            wb_dat_o <= {24'h000000, rd_s};
         end
      end
   end
endmodule : ppsid_regs

// ### bench/ppsid_regs_properties.sv
`timescale 1ns/1ps
module ppsid_regs_chk
   import ppsid_pkg::*;
(
   input wire logic                 clk_i,
   input wire logic                 rst_i,
   input wire logic                 ce_i,
   input wire logic                 wb_cyc_i,
   input wire logic                 wb_stb_i,
   input wire logic                 wb_we_i,
   input wire logic [5:0]           wb_adr_i,
   input wire logic [31:0]          wb_dat_i,
   input wire logic [3:0]           wb_sel_i,
   input wire logic [31:0]          wb_dat_o,
   input wire logic                 wb_ack_o,
   input wire logic [NUM_PORTS-1:0] port_disable_o,
   input wire logic                 irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic       tk = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce_i;
   // byte lane 0 gates writes in the slave, so the mirror follows it
   wire logic       tw = tk & wb_we_i & wb_sel_i[0];
   wire logic [3:0] ix = wb_adr_i[5:2];
   logic [2:0]      pg_q;
   logic [3:0]      pt_q;
   logic            mk_q;
   // mirror of selector and mask, so page reads can be predicted
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {pg_q, pt_q, mk_q} <= 8'h00;
      end else if (tw && ix == IDX_PAGE_PORT) begin
         {pg_q, pt_q} <= wb_dat_i[6:0];
      end else if (tw && ix == IDX_IRQ_MASK) begin
         mk_q <= wb_dat_i[0];
      end
   end
   wire logic rd = tk & ~wb_we_i & ix[3];
   wire logic rp = rd & (pg_q == PAGE_PORT);

   ack_after_req_a: assert property (tk |=> wb_ack_o)
      else $error("ack missing");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("upper read data set");
   reset_quiet_a: assert property (disable iff (1'b0)
      rst_i |=> !wb_ack_o && !irq_o && port_disable_o == '0)
      else $error("outputs live after reset");
   dis_write_a: assert property (tw && ix == IDX_PG_LINE &&
      pg_q == PAGE_PORT && pt_q == 4'h0 |-> ##2
      port_disable_o[0] == $past(wb_dat_i[0], 2)) else $error("bad disable");
   compliance_level_a: assert property (
      rd && pg_q == PAGE_IDENT && ix == IDX_PG_LINE |=> wb_dat_o == 32'h01)
      else $error("bad compliance level");
   vend_zero_a: assert property (
      rd && pg_q == PAGE_VEND |=> wb_dat_o == 32'h0)
      else $error("vendor page not zero");
   absent_port_a: assert property (
      rp && pt_q >= NUM_PORTS |=> wb_dat_o == 32'h0)
      else $error("absent port not zero");
   speed_cap_a: assert property (
      rp && ix == IDX_PG_SPEED |=> wb_dat_o[7:5] <= SPEED_MAX)
      else $error("speed code above 010");
   irq_mask_a: assert property (!mk_q && !$past(mk_q) |-> !irq_o)
      else $error("masked interrupt raised");

   cover property (rp);
   cover property ($rose(irq_o));
   cover property (rd && pg_q == PAGE_IDENT);
endmodule : ppsid_regs_chk

bind ppsid_regs ppsid_regs_chk i_ppsid_regs_chk (.clk_i, .rst_i, .ce_i,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o,
   .wb_ack_o, .port_disable_o, .irq_o);

// ### bench/ppsid_llc_model.sv
`timescale 1ns/1ps
module ppsid_llc_model
   import ppsid_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic        wb_ack_i,
   output logic             wb_cyc_o,
   output logic             wb_stb_o,
   output logic             wb_we_o,
   output logic [5:0]       wb_adr_o,
   output logic [31:0]      wb_dat_o,
   output logic [3:0]       wb_sel_o
);
   initial begin
      {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_dat_o} = '0;
      wb_sel_o = 4'hF;
   end

   // request held until ack is sampled; no latency is assumed
   task automatic acc(input logic w, input logic [3:0] ix,
                      input logic [7:0] d, output logic [7:0] q);
      int n;
      @(posedge clk_i);
      {wb_cyc_o, wb_stb_o} <= 2'h3;
      wb_we_o <= w;
      wb_adr_o <= {ix, 2'h0};
      wb_dat_o <= {24'h0, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_i !== 1'b1 && n < 100);
      q = wb_dat_i[7:0];
      {wb_cyc_o, wb_stb_o} <= 2'h0;
      if (n >= 100) begin
         $display("ERROR wb_ack_i expected 1 seen 0");
         ppsid_regs_tb_top.n_fail++;
         ppsid_regs_tb_top.summarize();
      end
   endtask : acc

   task automatic sel(input logic [2:0] page, input logic [3:0] port);
      logic [7:0] q;
      acc(1'b1, IDX_PAGE_PORT, {1'b0, page, port}, q);
   endtask : sel
endmodule : ppsid_llc_model

// ### bench/ppsid_regs_tb_top.sv
`timescale 1ns/1ps
module ppsid_regs_tb_top;
   import ppsid_pkg::*;
   logic clk_i, rst_i, ce_i, bus_reset_i, tree_id_done_i, self_id_done_i;
   logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
   logic [5:0]     wb_adr_i;
   logic [31:0]    wb_dat_i, wb_dat_o;
   logic [3:0]     wb_sel_i;
   logic [1:0]     port_disable_o;
   logic [7:0]     q;
   logic [63:0]    idv;
   int             n_fail, cmp_count, i;
   logic [2:0]     spd [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h7};
   ppsid_port_in_t port_i [NUM_PORTS];

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   ppsid_regs i_ppsid_regs (.clk_i, .rst_i, .ce_i, .bus_reset_i,
      .tree_id_done_i, .self_id_done_i, .port_i, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o,
      .port_disable_o, .irq_o);
   ppsid_llc_model i_ppsid_llc_model (.clk_i, .wb_dat_i(wb_dat_o),
      .wb_ack_i(wb_ack_o), .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i),
      .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_dat_o(wb_dat_i),
      .wb_sel_o(wb_sel_i));

   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] s);
      cmp_count++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic rc(input logic [3:0] ix, input logic [7:0] e);
      i_ppsid_llc_model.acc(1'b0, ix, 8'h00, q);
      chk($sformatf("index %h", ix), e, q);
   endtask : rc

   task automatic wr(input logic [3:0] ix, input logic [7:0] d);
      logic [7:0] unused;
      i_ppsid_llc_model.acc(1'b1, ix, d, unused);
   endtask : wr

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize

   initial begin
      {rst_i, ce_i, tree_id_done_i, self_id_done_i} = 4'hF;
      bus_reset_i = 1'b0;
      port_i[0] = '0;
      port_i[1] = '0;
      n_fail = 0;
      cmp_count = 0;
      idv = {8'h01, 8'h00, MAKER_OUI_VAL, PART_CODE_VAL};
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      rc(IDX_PAGE_PORT, 8'h00);
      i_ppsid_llc_model.sel(PAGE_IDENT, 4'h0);
      for (i = 0; i < 8; i++) begin
         rc(4'h8 + i[3:0], idv[63-8*i -: 8]);
      end
      wr(IDX_PG_LINE, 8'hFF);
      rc(IDX_PG_LINE, 8'h01);
      port_i[0] <= '{2'h3, 2'h2, 1'b0, 1'b0, 1'b1, 3'h0, 1'b0, 1'b0};
      port_i[1] <= '{2'h1, 2'h1, 1'b0, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0};
      i_ppsid_llc_model.sel(PAGE_PORT, 4'h0);
      rc(IDX_PG_LINE, 8'hE8);
      i_ppsid_llc_model.sel(PAGE_PORT, 4'h1);
      rc(IDX_PG_LINE, 8'h58);
      i_ppsid_llc_model.sel(PAGE_PORT, 4'h5);
      rc(IDX_PG_LINE, 8'h00);
      rc(IDX_PG_SPEED, 8'h00);
      i_ppsid_llc_model.sel(PAGE_VEND, 4'h0);
      rc(IDX_PAGE_PORT, 8'h70);
      rc(IDX_PG_LINE, 8'h00);
      repeat (BIAS_DEB_CYC) @(posedge clk_i);
      i_ppsid_llc_model.sel(PAGE_PORT, 4'h0);
      rc(IDX_PG_LINE, 8'hEA);
      wr(IDX_PG_LINE, 8'h01);
      bus_reset_i <= 1'b1;
      @(posedge clk_i);
      bus_reset_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk("port_disable_o", 8'h01, {6'h0, port_disable_o});
      wr(IDX_PG_LINE, 8'h00);
      for (i = 0; i < 5; i++) begin
         port_i[0].peer_speed <= spd[i];
         repeat (2) @(posedge clk_i);
         i_ppsid_llc_model.acc(1'b0, IDX_PG_SPEED, 8'h00, q);
         chk("speed",
             (spd[i] > 3'h2) ? 8'h02 : {5'h0, spd[i]},
             {5'h0, q[7:5]});
      end
      wr(IDX_IRQ_MASK, 8'h01);
      rc(IDX_IRQ_MASK, 8'h01);
      wr(IDX_PG_SPEED, 8'h10);
      port_i[0].resume_fault <= 1'b1;
      @(posedge clk_i);
      port_i[0].resume_fault <= 1'b0;
      rc(IDX_IRQ_STAT, 8'h01);
      chk("irq_o", 8'h01, {7'h0, irq_o});
      i_ppsid_llc_model.acc(1'b0, IDX_PG_SPEED, 8'h00, q);
      chk("fault", 8'h03, {6'h0, q[4:3]});
      wr(IDX_PG_SPEED, 8'h18);
      i_ppsid_llc_model.acc(1'b0, IDX_PG_SPEED, 8'h00, q);
      chk("fault clear", 8'h00, {7'h0, q[3]});
      wr(IDX_IRQ_STAT, 8'h01);
      rc(IDX_IRQ_STAT, 8'h00);
      wr(IDX_IRQ_MASK, 8'h00);
      port_i[0].suspend_fault <= 1'b1;
      @(posedge clk_i);
      port_i[0].suspend_fault <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk("irq masked", 8'h00, {7'h0, irq_o});
      i_ppsid_llc_model.acc(1'b0, IDX_PG_SPEED, 8'h00, q);
      chk("suspend fault", 8'h01, {7'h0, q[3]});
      rc(IDX_IRQ_STAT, 8'h01);
      // a fault seen while the enable is low must not be latched
      ce_i <= 1'b0;
      port_i[1].resume_fault <= 1'b1;
      repeat (2) @(posedge clk_i);
      port_i[1].resume_fault <= 1'b0;
      ce_i <= 1'b1;
      i_ppsid_llc_model.sel(PAGE_PORT, 4'h1);
      i_ppsid_llc_model.acc(1'b0, IDX_PG_SPEED, 8'h00, q);
      chk("frozen fault", 8'h00, {7'h0, q[3]});
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rc(IDX_PAGE_PORT, 8'h00);
      i_ppsid_llc_model.acc(1'b0, IDX_PG_SPEED, 8'h00, q);
      chk("fault after reset", 8'h00, {6'h0, q[4:3]});
      summarize();
   end
endmodule : ppsid_regs_tb_top
